// ===== pis_slave.sv
// Purpose: Slave end: decodes the two-wire link into register writes and reads
// Assumes: Link clock and data sampled by two flops each on clock_i
// Notes:   Register writes leave through a FIFO as {addr, data} words
`timescale 1ns/1ns
`default_nettype none
module pis_slave
    import pis_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    pis_if.slave             link,
    output logic             wr_valid_o,
    input  wire logic        wr_ready_i,
    output logic [15:0]      wr_data_o,
    output logic [7:0]       rd_addr_o,
    input  wire logic [7:0]  rd_data_i,
    output logic             busy_o
);
    typedef enum {PIS_IDLE, PIS_ADDR, PIS_REG, PIS_DATA, PIS_READ, PIS_ACK, PIS_RACK, PIS_SKIP} pis_state_t;

    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_q;
    logic        sda_q;
    pis_state_t  state;
    pis_state_t  next_state;
    pis_state_t  after_ack;
    pis_state_t  next_after_ack;
    logic [3:0]  bit_cnt;
    logic [3:0]  next_bit_cnt;
    logic [7:0]  shreg;
    logic [7:0]  next_shreg;
    logic [7:0]  reg_ptr;
    logic [7:0]  next_reg_ptr;
    logic        sda_drv;
    logic        next_sda_drv;
    logic        push;
    logic        next_push;
    logic        fifo_ready;
    logic        scl_rise;
    logic        scl_fall;
    logic        start_seen;
    logic        stop_seen;

    // Two-flop synchronisers; the first stage feeds nothing else
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            scl_sync <= 2'h3;
            sda_sync <= 2'h3;
            scl_q    <= 1'b1;
            sda_q    <= 1'b1;
        end else begin
            scl_sync <= {scl_sync[0], link.scl};
            sda_sync <= {sda_sync[0], link.sda};
            scl_q    <= scl_sync[1];
            sda_q    <= sda_sync[1];
        end
    end

    // Edge and condition detection, all timed by clock_i
    assign scl_rise   = scl_sync[1] && !scl_q;
    assign scl_fall   = !scl_sync[1] && scl_q;
    assign start_seen = scl_sync[1] && scl_q && sda_q && !sda_sync[1];
    assign stop_seen  = scl_sync[1] && scl_q && !sda_q && sda_sync[1];

    // Byte engine
    always_comb begin
        next_state     = state;
        next_after_ack = after_ack;
        next_bit_cnt   = bit_cnt;
        next_shreg     = shreg;
        next_reg_ptr   = reg_ptr;
        next_sda_drv   = sda_drv;
        next_push      = 1'b0;
        if (start_seen) begin
            // Repeated start behaves as the first one
            next_state   = PIS_ADDR;
            next_bit_cnt = '0;
            next_sda_drv = 1'b0;
        end else if (stop_seen) begin
            next_state   = PIS_IDLE;
            next_sda_drv = 1'b0;
        end else begin
            unique case (state)
                PIS_IDLE, PIS_SKIP: begin
                    next_sda_drv = 1'b0; // Released until next start
                end
                PIS_ADDR, PIS_REG, PIS_DATA: begin
                    if (scl_rise) begin
                        next_shreg   = {shreg[6:0], sda_sync[1]}; // MSB first
                        next_bit_cnt = bit_cnt + 4'h1;
                    end
                    if (scl_fall && bit_cnt == BIT_LAST + 4'h1) begin
                        next_bit_cnt = '0;
                        next_state   = PIS_ACK;
                        next_sda_drv = 1'b1; // Ack on ninth pulse
                        unique case (state)
                            PIS_ADDR: begin
                                if (shreg[7:1] != CHIP_ADDR) begin
                                    next_state   = PIS_SKIP;
                                    next_sda_drv = 1'b0;
                                end else if (shreg[0] == DIR_READ) begin
                                    next_after_ack = PIS_READ;
                                end else begin
                                    next_after_ack = PIS_REG;
                                end
                            end
                            PIS_REG: begin
                                next_reg_ptr   = shreg;
                                next_after_ack = PIS_DATA;
                            end
                            default: begin
                                // Hold the ack back while the FIFO is full
                                next_sda_drv   = fifo_ready;
                                next_push      = fifo_ready;
                                next_after_ack = PIS_REG; // Pairs repeat until stop
                            end
                        endcase
                    end
                end
                PIS_ACK: begin
                    if (scl_fall) begin
                        next_state   = after_ack;
                        next_sda_drv = 1'b0;
                        if (after_ack == PIS_READ) begin
                            next_shreg   = rd_data_i;
                            next_sda_drv = !rd_data_i[7];
                            next_bit_cnt = 4'h1;
                        end
                    end
                end
                PIS_READ: begin
                    // Change data only while clock is low
                    if (scl_fall) begin
                        if (bit_cnt == BIT_LAST + 4'h1) begin
                            next_sda_drv = 1'b0;
                            next_state   = PIS_RACK;
                        end else begin
                            next_sda_drv = !shreg[3'(BIT_LAST - bit_cnt)];
                            next_bit_cnt = bit_cnt + 4'h1;
                        end
                    end
                end
                PIS_RACK: begin
                    // Master answer not sampled; any answer ends driving
                    if (scl_rise) begin
                        next_state = PIS_SKIP;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state     <= PIS_IDLE;
            after_ack <= PIS_IDLE;
            bit_cnt   <= '0;
            shreg     <= '0;
            reg_ptr   <= '0;
            sda_drv   <= 1'b0;
            push      <= 1'b0;
        end else begin
            state     <= next_state;
            after_ack <= next_after_ack;
            bit_cnt   <= next_bit_cnt;
            shreg     <= next_shreg;
            reg_ptr   <= next_reg_ptr;
            sda_drv   <= next_sda_drv;
            push      <= next_push;
        end
    end

    assign link.sda_oe_s = sda_drv;
    assign rd_addr_o     = reg_ptr;
    assign busy_o        = (state != PIS_IDLE); // Bus busy from start to stop

    // Write words buffered so the register side may stall
    pis_fifo #(
        .WIDTH (FIFO_WIDTH),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clock_i     (clock_i),
        .rst_b_i     (rst_b_i),
        .in_valid_i  (push),
        .in_ready_o  (fifo_ready),
        .in_data_i   ({reg_ptr, shreg}),
        .out_valid_o (wr_valid_o),
        .out_ready_i (wr_ready_i),
        .out_data_o  (wr_data_o)
    );
endmodule
`default_nettype wire

// ===== pis_pkg.sv
// Purpose: Shared constants for the power-controller serial register link
// Assumes: Both ends run on one 10 MHz system clock; the link clock is sampled
// Notes:   Contract list follows
// Contract
// - Device is slave only, timed by serial clock
// - Link bit rate at most 400 kbit/s
// - Data changes only while clock is low
// - Data falling with clock high starts session
// - Data rising with clock high ends session
// - Master alone makes start and stop
// - Repeated start restarts address reception
// - Bytes are eight bits, MSB first
// - Ninth pulse: sender releases, receiver pulls low; the master releases the slot after the read byte
// - Addressed slave acknowledges every received byte; data bytes not acked while FIFO full
// - First byte: seven-bit address plus direction bit
// - Write: second byte register, third byte data
// - Slave answers only chip address 60h
// - Master writes register address before reading
// - Multi-byte write: address once, then pairs
package pis_pkg;
    localparam int          SYS_CLK_HZ     = 10_000_000;
    localparam int          LINK_MAX_BPS   = 400_000;
    // Half of the shortest legal bit period, rounded up
    localparam int          HALF_BIT_CYC   = (SYS_CLK_HZ + 2 * LINK_MAX_BPS - 1) / (2 * LINK_MAX_BPS);
    localparam logic [6:0]  CHIP_ADDR      = 7'h60;
    localparam int          BYTE_BITS      = 8;
    localparam logic [3:0]  BIT_LAST       = 4'h7;
    localparam logic        DIR_WRITE      = 1'b0;
    localparam logic        DIR_READ       = 1'b1;
    localparam int          FIFO_WIDTH     = 16;
    localparam int          FIFO_DEPTH     = 16;
    localparam int          REG_COUNT      = 256;
endpackage

// ===== pis_if.sv
// Purpose: Two-wire link joining master and slave ends
// Assumes: Open-drain wires with pull-ups resolved here
// Notes:   Each end drives low only when its enable is high
`timescale 1ns/1ns
`default_nettype none
interface pis_if;
    logic scl_oe_m;
    logic sda_oe_m;
    logic sda_oe_s;
    logic scl;
    logic sda;
    // Wired-AND of both ends on data, master alone on clock, with pull-up
    assign scl = ~scl_oe_m;
    assign sda = ~(sda_oe_m | sda_oe_s);
    modport master (output scl_oe_m, output sda_oe_m, input scl, input sda);
    modport slave  (output sda_oe_s, input scl, input sda);
endinterface
`default_nettype wire

// ===== pis_fifo.sv
// Purpose: Parameterised flip-flop FIFO with valid/ready both sides
// Assumes: One clock, synchronous active-low reset
// Notes:   Full and empty come straight from the occupancy count
`timescale 1ns/1ns
`default_nettype none
module pis_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16
) (
    input  wire logic             clock_i,
    input  wire logic             rst_b_i,
    input  wire logic             in_valid_i,
    output logic                  in_ready_o,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  out_valid_o,
    input  wire logic             out_ready_i,
    output logic      [WIDTH-1:0] out_data_o
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [AW:0]      count;
    logic [AW-1:0]    next_wr_ptr;
    logic [AW-1:0]    next_rd_ptr;
    logic [AW:0]      next_count;
    logic             push;
    logic             pop;

    assign in_ready_o  = (count != (AW+1)'(DEPTH));
    assign out_valid_o = (count != '0);
    assign out_data_o  = mem[rd_ptr];
    assign push        = in_valid_i && in_ready_o;
    assign pop         = out_valid_o && out_ready_i;

    // Pointer and count update
    always_comb begin
        next_wr_ptr = push ? wr_ptr + 1'b1 : wr_ptr;
        next_rd_ptr = pop ? rd_ptr + 1'b1 : rd_ptr;
        next_count  = count + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count  <= '0;
        end else begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count  <= next_count;
        end
    end

    // Storage needs no reset; empty hides stale words
    always_ff @(posedge clock_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end
endmodule
`default_nettype wire

// ===== pis_master.sv
// Purpose: Master end: issues one register write or read per command
// Assumes: Clock made by divider from clock_i, never above 400 kbit/s
// Notes:   Read is always write of register address then repeated start
`timescale 1ns/1ns
`default_nettype none
module pis_master
    import pis_pkg::*;
(
    input  wire logic        clock_i,
    input  wire logic        rst_b_i,
    pis_if.master            link,
    input  wire logic        cmd_valid_i,
    output logic             cmd_ready_o,
    input  wire logic        cmd_read_i,
    input  wire logic [7:0]  cmd_reg_i,
    input  wire logic [7:0]  cmd_data_i,
    output logic             done_o,
    output logic [7:0]       rd_data_o,
    output logic             nack_o
);
    typedef enum {PIM_IDLE, PIM_START, PIM_BIT, PIM_STOP} pis_mst_t;

    logic [1:0]  sda_sync;
    pis_mst_t    state;
    pis_mst_t    next_state;
    logic [5:0]  div;
    logic [5:0]  next_div;
    logic [1:0]  phase;
    logic [1:0]  next_phase;
    logic [5:0]  idx;
    logic [5:0]  next_idx;
    logic [44:0] frame;
    logic [44:0] next_frame;
    logic        rd;
    logic        next_rd;
    logic [7:0]  rdat;
    logic [7:0]  next_rdat;
    logic        nack;
    logic        next_nack;
    logic        scl_oe;
    logic        next_scl_oe;
    logic        sda_oe;
    logic        next_sda_oe;
    logic        done;
    logic        next_done;
    logic        tick;
    logic [5:0]  last_idx;

    // Quarter-bit enable; four quarters give one bit under the rate cap
    assign tick     = (div == 6'(HALF_BIT_CYC / 2));
    assign last_idx = rd ? 6'd36 : 6'd26;
    assign cmd_ready_o = (state == PIM_IDLE);

    // Bit sequencer; master alone frames sessions
    always_comb begin
        next_state  = state;
        next_div    = tick ? '0 : div + 6'h1;
        next_phase  = phase;
        next_idx    = idx;
        next_frame  = frame;
        next_rd     = rd;
        next_rdat   = rdat;
        next_nack   = nack;
        next_scl_oe = scl_oe;
        next_sda_oe = sda_oe;
        next_done   = 1'b0;
        unique case (state)
            PIM_IDLE: begin
                if (cmd_valid_i) begin
                    // Address, register, then data or restart plus read
                    next_rd    = cmd_read_i;
                    next_frame = cmd_read_i ?
                        {CHIP_ADDR, DIR_WRITE, 1'b1, cmd_reg_i, 1'b1, 1'b1,
                         CHIP_ADDR, DIR_READ, 1'b1, 8'hff, 1'b1, 8'hff} :
                        {CHIP_ADDR, DIR_WRITE, 1'b1, cmd_reg_i, 1'b1, cmd_data_i, 1'b1, 18'h3ffff};
                    next_idx   = '0;
                    next_phase = '0;
                    next_nack  = 1'b0;
                    next_state = PIM_START;
                end
            end
            PIM_START: begin
                if (tick) begin
                    next_phase = phase + 2'h1;
                    if (phase == 2'h1) begin
                        next_sda_oe = 1'b1; // Data falls, clock high
                    end else if (phase == 2'h3) begin
                        next_scl_oe = 1'b1;
                        next_state  = PIM_BIT;
                    end
                end
            end
            PIM_BIT: begin
                if (tick) begin
                    next_phase = phase + 2'h1;
                    unique case (phase)
                        2'h0: next_sda_oe = !frame[44]; // Change while clock low
                        2'h1: next_scl_oe = 1'b0;
                        2'h2: begin
                            if (rd && idx == 6'd18) begin
                                next_sda_oe = 1'b0;
                                next_state  = PIM_START; // Repeated start
                                next_phase  = '0;
                                next_idx    = idx + 6'h1;
                                next_frame  = {frame[43:0], 1'b1};
                            end
                            if (rd && idx >= 6'd28 && idx <= 6'd35) begin
                                next_rdat = {rdat[6:0], sda_sync[1]}; // Read byte MSB first
                            end
                            if ((idx == 6'd8 || idx == 6'd17 || idx == (rd ? 6'd27 : 6'd26)) && sda_sync[1]) begin
                                next_nack = 1'b1; // Slave ack missing
                            end
                        end
                        default: begin
                            next_scl_oe = 1'b1;
                            next_frame  = {frame[43:0], 1'b1};
                            next_idx    = idx + 6'h1;
                            if (idx == last_idx) begin
                                next_sda_oe = 1'b1;
                                next_state  = PIM_STOP;
                                next_phase  = '0;
                            end
                        end
                    endcase
                end
            end
            PIM_STOP: begin
                if (tick) begin
                    next_phase = phase + 2'h1;
                    if (phase == 2'h1) begin
                        next_scl_oe = 1'b0;
                    end else if (phase == 2'h2) begin
                        next_sda_oe = 1'b0; // Data rises, clock high
                    end else if (phase == 2'h3) begin
                        next_done  = 1'b1;
                        next_state = PIM_IDLE;
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            state    <= PIM_IDLE;
            div      <= '0;
            phase    <= '0;
            idx      <= '0;
            frame    <= '1;
            rd       <= 1'b0;
            rdat     <= '0;
            nack     <= 1'b0;
            scl_oe   <= 1'b0;
            sda_oe   <= 1'b0;
            done     <= 1'b0;
            sda_sync <= 2'h3;
        end else begin
            state    <= next_state;
            div      <= next_div;
            phase    <= next_phase;
            idx      <= next_idx;
            frame    <= next_frame;
            rd       <= next_rd;
            rdat     <= next_rdat;
            nack     <= next_nack;
            scl_oe   <= next_scl_oe;
            sda_oe   <= next_sda_oe;
            done     <= next_done;
            sda_sync <= {sda_sync[0], link.sda};
        end
    end

    assign link.scl_oe_m = scl_oe;
    assign link.sda_oe_m = sda_oe;
    assign done_o        = done;
    assign rd_data_o     = rdat;
    assign nack_o        = nack;
endmodule
`default_nettype wire

// ===== pis_link_props.sv
// Purpose: Wire-level checks on the two-wire link between master and slave
// Assumes: Link wires sampled on clock_i; reset synchronous, active low
// Notes:   Bit and byte position are rebuilt here from start and clock rises
`timescale 1ns/1ns
`default_nettype none
module pis_link_props
    import pis_pkg::*;
(
    input  wire logic clock_i,
    input  wire logic rst_b_i,
    input  wire logic sda_oe_m,
    input  wire logic sda_oe_s,
    input  wire logic scl,
    input  wire logic sda
);
    localparam int MIN_PER = SYS_CLK_HZ / LINK_MAX_BPS;
    logic       scl_q, sda_q, dir, next_dir, start, stop, rise, rd_byte;
    logic [3:0] bit_cnt, next_bit_cnt;
    logic [2:0] byte_idx, next_byte_idx;
    logic [7:0] per_cnt, next_per_cnt;

    // Frame position; a start, first or repeated, clears it
    always_comb begin
        start = scl && scl_q && sda_q && !sda;
        stop = scl && scl_q && !sda_q && sda;
        rise = scl && !scl_q;
        rd_byte = dir && (byte_idx == 3'h1);
        next_bit_cnt = bit_cnt;
        next_byte_idx = byte_idx;
        next_dir = dir;
        next_per_cnt = rise ? 8'h01 : ((per_cnt == 8'hff) ? per_cnt : per_cnt + 8'h01);
        if (start) begin
            next_bit_cnt = 4'h0;
            next_byte_idx = 3'h0;
        end else if (rise) begin
            next_bit_cnt = (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
            if (bit_cnt == 4'h8 && byte_idx != 3'h7) begin
                next_byte_idx = byte_idx + 3'h1;
            end
            if (bit_cnt == 4'h7 && byte_idx == 3'h0) begin
                next_dir = sda;
            end
        end
    end

    // Period counter saturates so the first rise after idle never fails
    always_ff @(posedge clock_i) begin
        if (!rst_b_i) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            dir <= 1'b0;
            bit_cnt <= 4'h0;
            byte_idx <= 3'h0;
            per_cnt <= 8'hff;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
            dir <= next_dir;
            bit_cnt <= next_bit_cnt;
            byte_idx <= next_byte_idx;
            per_cnt <= next_per_cnt;
        end
    end

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);

    a_addr_ack:    assert property (rise && bit_cnt == 4'h8 && byte_idx == 3'h0 |-> sda_oe_s)
        else $error("address byte not acknowledged by slave");
    a_write_quiet: assert property (rise && bit_cnt < 4'h8 && !rd_byte |-> !sda_oe_s)
        else $error("slave drives data while master sends");
    a_ack_release: assert property (rise && bit_cnt == 4'h8 && !rd_byte |-> !sda_oe_m)
        else $error("master holds data in acknowledge slot");
    a_read_master: assert property (rise && bit_cnt < 4'h8 && rd_byte |-> !sda_oe_m)
        else $error("master drives data during read byte");
    a_read_nack:   assert property (rise && bit_cnt == 4'h8 && rd_byte |-> !sda_oe_s && !sda_oe_m)
        else $error("read byte not closed by released slot");
    a_slave_edge:  assert property ($changed(sda_oe_s) |-> !scl)
        else $error("slave changes data while clock high");
    a_stop_release: assert property (stop |=> !sda_oe_s [*8])
        else $error("slave drives data after stop");
    a_bit_rate:    assert property (rise |-> int'(per_cnt) >= MIN_PER)
        else $error("link clock faster than allowed");

    c_read_slot:  cover property (rise && bit_cnt == 4'h8 && rd_byte);
    c_data_nack:  cover property (rise && bit_cnt == 4'h8 && byte_idx == 3'h2 && !sda_oe_s);
    c_restart:    cover property (start && byte_idx == 3'h2);
endmodule
`default_nettype wire

// ===== testbench.sv
// Purpose: Drives master commands across the link and scores slave results
// Assumes: 10 MHz clock, reset held 20 cycles, random seed 47618
// Notes:   A second slave is driven bit by bit at 800 ns per bit
`timescale 1ns/1ns
`default_nettype none
module testbench
    import pis_pkg::*;
;
    logic        clock_i, rst_b_i, cmd_valid, cmd_read, cmd_ready, done, nack, wr_ready, wr_valid, busy;
    logic        tb_scl_oe, tb_sda_oe, b_valid, b_busy, a;
    logic [7:0]  cmd_reg, cmd_data, rd_data, rd_addr, r;
    logic [15:0] wr_data, b_data;
    logic [9:0]  note;
    logic [1:0]  mode;
    logic [15:0] exp_wr[$], exp_b[$];
    logic [9:0]  exp_done[$];
    int          seed = 47618;
    int          bad_count = 0;
    int          checks_done = 0;

    pis_if u_link ();
    pis_if u_link_b ();
    assign u_link_b.scl_oe_m = tb_scl_oe;
    assign u_link_b.sda_oe_m = tb_sda_oe;

    pis_master u_pis_master (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(u_link), .cmd_valid_i(cmd_valid),
        .cmd_ready_o(cmd_ready), .cmd_read_i(cmd_read), .cmd_reg_i(cmd_reg), .cmd_data_i(cmd_data),
        .done_o(done), .rd_data_o(rd_data), .nack_o(nack));
    // Register contents seen by the slave are a fixed function of the address
    pis_slave u_pis_slave (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(u_link), .wr_valid_o(wr_valid),
        .wr_ready_i(wr_ready), .wr_data_o(wr_data), .rd_addr_o(rd_addr), .rd_data_i(rd_addr ^ 8'h3c),
        .busy_o(busy));
    pis_slave u_pis_slave_b (.clock_i(clock_i), .rst_b_i(rst_b_i), .link(u_link_b), .wr_valid_o(b_valid),
        .wr_ready_i(1'b1), .wr_data_o(b_data), .rd_addr_o(), .rd_data_i(8'h00), .busy_o(b_busy));
    pis_link_props u_props (.clock_i(clock_i), .rst_b_i(rst_b_i), .sda_oe_m(u_link.sda_oe_m),
        .sda_oe_s(u_link.sda_oe_s), .scl(u_link.scl), .sda(u_link.sda));

    // Clock at 100 ns
    initial begin
        clock_i = 1'b0;
        forever #50 clock_i = ~clock_i;
    end

    task automatic cmp16(input logic [15:0] e, input logic [15:0] g);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("wrong value at %0t: expected %h got %h", $time, e, g);
        end
    endtask

    task automatic cmp8(input logic [7:0] e, input logic [7:0] g);
        cmp16({8'h00, e}, {8'h00, g});
    endtask

    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    // One master command; notes its results, waits for done under a bound
    task automatic run_cmd(input logic rd, input logic [7:0] rg, input logic [7:0] d, input logic nk);
        int n;
        n = 0;
        exp_done.push_back({rd, nk, rd ? (rg ^ 8'h3c) : 8'h00});
        if (!rd && !nk) exp_wr.push_back({rg, d});
        cmd_valid <= 1'b1;
        cmd_read <= rd;
        cmd_reg <= rg;
        cmd_data <= d;
        do @(posedge clock_i); while (!cmd_ready);
        cmd_valid <= 1'b0;
        while (done !== 1'b1 && n < 3000) begin
            @(posedge clock_i);
            n++;
        end
        if (n >= 3000) bad_count++;
        @(posedge clock_i);
    endtask

    // Bit-bang one link bit on the second slave; data moves only while clock low
    task automatic lb_bit(input logic b, output logic s);
        tb_sda_oe <= !b;
        repeat (2) @(posedge clock_i);
        tb_scl_oe <= 1'b0;
        repeat (2) @(posedge clock_i);
        s = u_link_b.sda;
        repeat (2) @(posedge clock_i);
        tb_scl_oe <= 1'b1;
        repeat (2) @(posedge clock_i);
    endtask

    task automatic lb_byte(input logic [7:0] v, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) lb_bit(v[i], s);
        lb_bit(1'b1, ack);
    endtask

    // Start from idle or from clock low; stop when end is set
    task automatic lb_cond(input logic fin);
        tb_sda_oe <= fin;
        repeat (2) @(posedge clock_i);
        tb_scl_oe <= 1'b0;
        repeat (4) @(posedge clock_i);
        tb_sda_oe <= !fin;
        repeat (4) @(posedge clock_i);
        if (!fin) tb_scl_oe <= 1'b1;
        repeat (2) @(posedge clock_i);
    endtask

    // Slave write port stalls at random, or stalls or drains on demand
    always @(posedge clock_i) wr_ready <= (mode == 2'h0) ? 1'($random(seed)) : (mode == 2'h2);

    // Scoreboard: oldest note is taken whenever a result appears
    always @(posedge clock_i) begin
        if (rst_b_i && wr_valid && wr_ready) cmp16(exp_wr.size() ? exp_wr.pop_front() : 16'hxxxx, wr_data);
        if (rst_b_i && b_valid) cmp16(exp_b.size() ? exp_b.pop_front() : 16'hxxxx, b_data);
        if (rst_b_i && done) begin
            note = exp_done.size() ? exp_done.pop_front() : 10'h3ff;
            cmp8({7'h00, note[8]}, {7'h00, nack});
            if (note[9]) cmp8(note[7:0], rd_data);
            cmp8(8'h00, {7'h00, busy});
        end
    end

    initial begin
        repeat (60000) @(posedge clock_i);
        bad_count++;
        close_out();
    end

    initial begin
        rst_b_i = 1'b0;
        {cmd_valid, cmd_read, cmd_reg, cmd_data, mode} = '0;
        {tb_scl_oe, tb_sda_oe} = 2'b00;
        repeat (20) @(posedge clock_i);
        rst_b_i <= 1'b1;
        @(posedge clock_i);
        // Write then read the same register, boundary registers first
        for (int i = 0; i < 6; i++) begin
            r = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($random(seed));
            run_cmd(1'b0, r, 8'($random(seed)), 1'b0);
            run_cmd(1'b1, r, 8'h00, 1'b0);
        end
        $display("test write_read done");
        // Fill the buffer with the far side stalled, one more is refused
        mode <= 2'h2;
        repeat (40) @(posedge clock_i);
        mode <= 2'h1;
        @(posedge clock_i);
        for (int i = 0; i < 16; i++) run_cmd(1'b0, 8'(i), 8'($random(seed)), 1'b0);
        run_cmd(1'b0, 8'h55, 8'haa, 1'b1);
        cmp8(8'h01, {7'h00, wr_valid});
        mode <= 2'h2;
        repeat (40) @(posedge clock_i);
        cmp8(8'h00, {7'h00, wr_valid});
        mode <= 2'h0;
        $display("test buffer_full done");
        // Foreign address is ignored until a repeated start names this chip
        lb_cond(1'b0);
        lb_byte({CHIP_ADDR + 7'h01, DIR_WRITE}, a);
        cmp8(8'h01, {7'h00, a});
        lb_byte(8'h12, a);
        cmp8(8'h01, {7'h00, a});
        lb_cond(1'b0);
        repeat (2) exp_b.push_back(16'h5a96);
        lb_byte({CHIP_ADDR, DIR_WRITE}, a);
        cmp8(8'h00, {7'h00, a});
        repeat (2) begin
            lb_byte(8'h5a, a);
            cmp8(8'h00, {7'h00, a});
            lb_byte(8'h96, a);
            cmp8(8'h00, {7'h00, a});
        end
        cmp8(8'h01, {7'h00, b_busy});
        lb_cond(1'b1);
        repeat (4) @(posedge clock_i);
        cmp8(8'h00, {7'h00, b_busy});
        $display("test address_filter done");
        close_out();
    end
endmodule
`default_nettype wire
